// *** can_irq_pkg.sv ***
// package: constants, carriers and helpers for can interrupt and fifo control
// Functional notes
// - wake-up activity on the bus sets the wake flag, bit 14
// - any bus error sets the bus error flag, bit 13
// - a system bus error, such as illegal address, sets bit 12
// - a receive buffer overflow sets the receive overflow flag, bit 11
// - current mode matching the requested mode sets flag bit 3
// - free-running timer wrapping past its maximum sets bit 2
// - bit 1 is high exactly while a receive buffer interrupt is pending
// - bit 0 is high exactly while a transmit buffer interrupt is pending
// - the restricted flag clears only by turning the module off then on
// - aborted status updates on done, abort or fifo reset; 1 = aborted
// - losing bus arbitration sets that fifo's lost arbitration status
// - a bus error during transmission sets that fifo's transmit error status
// - any read of fifo control, or fifo reset, clears both error statuses
// - writing 1 requests sending; cleared when all queued messages are sent
// - writing 0 while the send request is 1 requests an abort
// - send request writes are ignored while the fifo is a receive fifo
// - with auto remote reply on, a received remote request sets send request
// - priority field: 11 highest, 10 high mid, 01 low mid, 00 lowest
// - fifo configuration bits change only in configuration mode, code 100
package can_irq_pkg;

    localparam int NUM_FIFOS = 32;
    localparam int FIFO_IDX_W = 5;
    localparam int ADDR_W = 12;
    localparam int TIMER_W = 16;

    // ==========================================
    // register map
    localparam logic [11:0] OFF_MODULE_CONTROL = 12'h000;
    localparam logic [11:0] OFF_INT_FLAGS = 12'h004;
    localparam logic [11:0] OFF_TIMER = 12'h008;
    localparam logic [11:0] OFF_DIRECTION = 12'h00C;
    localparam logic [11:0] FIFO_BASE = 12'h100;

    // ==========================================
    // field positions
    localparam int POS_ENABLE = 15;
    localparam int POS_CUR_MODE = 21;
    localparam int POS_REQ_MODE = 24;
    localparam int BIT_WAKE = 14;
    localparam int BIT_BUS_ERR = 13;
    localparam int BIT_SYS_ERR = 12;
    localparam int BIT_RX_OVF = 11;
    localparam int BIT_MODE = 3;
    localparam int BIT_TIMER = 2;
    localparam int BIT_RX_BUF = 1;
    localparam int BIT_TX_BUF = 0;
    // bits software may clear by writing 1; system error is not among them
    localparam logic [14:0] W1C_MASK = 15'h680C;

    // ==========================================
    // timer maximum and reset values
    localparam logic [TIMER_W-1:0] TIMER_MAX = 16'hFFFF;
    localparam logic [31:0] DIR_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b000,
        MODE_DISABLE = 3'b001,
        MODE_LOOPBACK = 3'b010,
        MODE_LISTEN = 3'b011,
        MODE_CONFIG = 3'b100,
        MODE_RSVD5 = 3'b101,
        MODE_RSVD6 = 3'b110,
        MODE_LISTEN_ALL = 3'b111
    } op_mode_t;

    localparam op_mode_t MODE_RESET = MODE_CONFIG;

    // per-fifo events from the protocol engine, one-cycle pulses
    typedef struct packed {
        logic done;
        logic aborted;
        logic lost_arb;
        logic bus_err;
        logic remote_rx;
        logic reset;
    } fifo_evt_t;

    // per-fifo control word, laid out as bits 6..0 of the register
    typedef struct packed {
        logic aborted;
        logic lost_arb;
        logic tx_err;
        logic send_req;
        logic rtr_en;
        logic [1:0] prio;
    } fifo_ctl_t;

    function automatic logic [31:0] merge_strb(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

endpackage

// *** can_fifo_ctl.sv ***
// module: control and status of one message fifo
`timescale 1ns/10ps
module can_fifo_ctl
    import can_irq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cfg_mode,
    input wire logic is_tx,
    input wire logic wr_en,
    input wire fifo_ctl_t wr_val,
    input wire logic rd_clear,
    input wire fifo_evt_t evt,
    output fifo_ctl_t ctl,
    output logic abort_req
);
    fifo_ctl_t ctl_r;
    fifo_ctl_t ctl_nxt;
    logic abort_r;
    logic abort_nxt;

    wire sw_set = wr_en & is_tx & wr_val.send_req & ~ctl_r.send_req;
    wire sw_abort = wr_en & is_tx & ~wr_val.send_req & ctl_r.send_req;
    wire rtr_set = evt.remote_rx & ctl_r.rtr_en & is_tx;
    wire finished = evt.done | evt.aborted;

    always_comb begin
        ctl_nxt = ctl_r;
        abort_nxt = abort_r;
        if (wr_en && cfg_mode) begin
            ctl_nxt.rtr_en = wr_val.rtr_en;
            ctl_nxt.prio = wr_val.prio;
        end
        if (rd_clear) begin
            ctl_nxt.lost_arb = 1'b0;
            ctl_nxt.tx_err = 1'b0;
        end
        // set beats the read clear in the same cycle
        if (evt.lost_arb) begin
            ctl_nxt.lost_arb = 1'b1;
        end
        if (evt.bus_err) begin
            ctl_nxt.tx_err = 1'b1;
        end
        if (sw_abort) begin
            abort_nxt = 1'b1;
        end
        if (finished) begin
            ctl_nxt.aborted = evt.aborted;
            ctl_nxt.send_req = 1'b0;
            abort_nxt = 1'b0;
        end
        if (sw_set || rtr_set) begin
            ctl_nxt.send_req = 1'b1;
        end
        if (evt.reset) begin
            ctl_nxt.aborted = 1'b0;
            ctl_nxt.lost_arb = 1'b0;
            ctl_nxt.tx_err = 1'b0;
            ctl_nxt.send_req = 1'b0;
            abort_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_r <= '0;
            abort_r <= 1'b0;
        end else begin
            ctl_r <= ctl_nxt;
            abort_r <= abort_nxt;
        end
    end

    assign ctl = ctl_r;
    assign abort_req = abort_r;

    a_abort_status: assert property (@(posedge aclk)
        disable iff (!aresetn)
        evt.aborted && !evt.reset && !sw_set && !rtr_set
        |=> ctl_r.aborted && !ctl_r.send_req)
        else $error("aborted status not set after abort");
    a_lost_arb_set: assert property (@(posedge aclk)
        disable iff (!aresetn)
        evt.lost_arb && !evt.reset |=> ctl_r.lost_arb)
        else $error("lost arbitration not recorded");
    a_tx_err_set: assert property (@(posedge aclk)
        disable iff (!aresetn)
        evt.bus_err && !evt.reset |=> ctl_r.tx_err)
        else $error("transmit error not recorded");
    a_read_clear: assert property (@(posedge aclk)
        disable iff (!aresetn)
        rd_clear && !evt.lost_arb && !evt.bus_err
        |=> !ctl_r.lost_arb && !ctl_r.tx_err)
        else $error("read did not clear error statuses");
    a_done_clear: assert property (@(posedge aclk)
        disable iff (!aresetn)
        evt.done && !evt.aborted && !sw_set && !rtr_set
        |=> !ctl_r.send_req && !ctl_r.aborted)
        else $error("send request not cleared on completion");
    a_abort_request: assert property (@(posedge aclk)
        disable iff (!aresetn)
        sw_abort && !finished && !evt.reset |=> abort_r && ctl_r.send_req)
        else $error("abort request not raised");
    a_rx_write_ignored: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !is_tx && !finished && !evt.reset
        |=> ctl_r.send_req == $past(ctl_r.send_req))
        else $error("send request changed in receive fifo");
    a_remote_reply: assert property (@(posedge aclk)
        disable iff (!aresetn)
        evt.remote_rx && !evt.reset && !evt.done && !evt.aborted
        |=> ctl_r.send_req == ($past(ctl_r.send_req) || $past(rtr_set)
        || $past(sw_set)))
        else $error("remote reply handling wrong");
    a_cfg_lock: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !cfg_mode |=> $stable(ctl_r.prio) && $stable(ctl_r.rtr_en))
        else $error("configuration changed outside config mode");

endmodule

// *** can_tx_arbiter.sv ***
// module: picks the pending fifo with the highest transmit priority
`timescale 1ns/10ps
module can_tx_arbiter
    import can_irq_pkg::*;
(
    input wire logic [NUM_FIFOS-1:0] req,
    input wire logic [NUM_FIFOS-1:0][1:0] prio,
    output logic valid,
    output logic [FIFO_IDX_W-1:0] index
);
    logic [1:0] best;

    // ties go to the lowest fifo number
    always_comb begin
        valid = 1'b0;
        index = '0;
        best = 2'b00;
        for (int i = 0; i < NUM_FIFOS; i++) begin
            if (req[i] && (!valid || prio[i] > best)) begin
                valid = 1'b1;
                index = FIFO_IDX_W'(i);
                best = prio[i];
            end
        end
    end

endmodule

// *** can_irq_and_tx_fifo_control.sv ***
// top: axi4-lite registers, interrupt flags and transmit fifo control
`timescale 1ns/10ps
module can_irq_and_tx_fifo_control
    import can_irq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wake_evt,
    input wire logic bus_err_evt,
    input wire logic sys_err_evt,
    input wire logic rx_ovf_evt,
    input wire logic rx_buf_pending,
    input wire logic tx_buf_pending,
    input wire fifo_evt_t [NUM_FIFOS-1:0] fifo_evt,
    output logic module_enable,
    output op_mode_t current_operating_mode,
    output logic [NUM_FIFOS-1:0] fifo_direction_select,
    output logic [NUM_FIFOS-1:0] send_request,
    output logic [NUM_FIFOS-1:0] abort_request,
    output logic [TIMER_W-1:0] free_running_timer,
    output logic tx_grant_valid,
    output logic [FIFO_IDX_W-1:0] tx_grant_index
);
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ==========================================
    // axi write channel
    logic aw_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic w_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    wire do_write = aw_held_r & w_held_r & ~bvalid_r;
    wire wr_ctl = do_write & (awaddr_r == OFF_MODULE_CONTROL);
    wire wr_int = do_write & (awaddr_r == OFF_INT_FLAGS);
    wire wr_tmr = do_write & (awaddr_r == OFF_TIMER);
    wire wr_dir = do_write & (awaddr_r == OFF_DIRECTION);
    wire wr_fifo_hit = (awaddr_r[11:7] == FIFO_BASE[11:7])
        & (awaddr_r[1:0] == 2'b00);
    wire wr_fifo = do_write & wr_fifo_hit;
    wire wr_known = wr_ctl | wr_int | wr_tmr | wr_dir | wr_fifo;
    wire [FIFO_IDX_W-1:0] wr_idx = awaddr_r[6:2];

    assign s_axi_awready = ~aw_held_r;
    assign s_axi_wready = ~w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
            w_held_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ==========================================
    // module control and mode tracking
    logic enable_r;
    op_mode_t req_mode_r;
    op_mode_t cur_mode_r;
    logic [31:0] ctl_word;
    logic [31:0] ctl_wr_word;

    assign ctl_word = {5'b0, req_mode_r, cur_mode_r, 5'b0, enable_r, 15'b0};
    assign ctl_wr_word = merge_strb(ctl_word, wdata_r, wstrb_r);
    // off-then-on is the only way the system error flag clears
    wire en_rise = wr_ctl & ctl_wr_word[POS_ENABLE] & ~enable_r;
    // one-cycle mode switch; the protocol engine sees the new mode one cycle after req_mode_r changes
    wire mode_step = (cur_mode_r != req_mode_r);
    wire cfg_mode = (cur_mode_r == MODE_CONFIG);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_r <= 1'b0;
            req_mode_r <= MODE_RESET;
            cur_mode_r <= MODE_RESET;
        end else begin
            if (wr_ctl) begin
                enable_r <= ctl_wr_word[POS_ENABLE];
                req_mode_r <= op_mode_t'(ctl_wr_word[POS_REQ_MODE +: 3]);
            end
            if (mode_step) begin
                cur_mode_r <= req_mode_r;
            end
        end
    end

    // ==========================================
    // free-running timer
    logic [TIMER_W-1:0] timer_r;
    wire timer_wrap = enable_r & (timer_r == TIMER_MAX);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_r <= '0;
        end else if (enable_r) begin
            timer_r <= timer_r + 16'h0001;
        end
    end

    // ==========================================
    // interrupt flags, set wins over clear
    logic [14:0] flags_r;
    logic [14:0] flag_set;
    logic [14:0] flag_clr;
    logic [31:0] int_word;
    logic [31:0] int_wr_word;

    always_comb begin
        flag_set = '0;
        flag_set[BIT_WAKE] = wake_evt;
        flag_set[BIT_BUS_ERR] = bus_err_evt;
        flag_set[BIT_SYS_ERR] = sys_err_evt;
        flag_set[BIT_RX_OVF] = rx_ovf_evt;
        flag_set[BIT_MODE] = mode_step;
        flag_set[BIT_TIMER] = timer_wrap;
    end

    assign int_word = {17'b0, flags_r[14:2], rx_buf_pending,
        tx_buf_pending};
    assign int_wr_word = merge_strb(32'h0000_0000, wdata_r, wstrb_r);
    always_comb begin
        flag_clr = wr_int ? (int_wr_word[14:0] & W1C_MASK) : 15'h0000;
        flag_clr[BIT_SYS_ERR] = en_rise;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r <= '0;
        end else begin
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end

    // ==========================================
    // fifo direction select, fifo controls and arbitration
    logic [NUM_FIFOS-1:0] dir_r;
    logic [31:0] dir_wr_word;
    fifo_ctl_t [NUM_FIFOS-1:0] fifo_ctl;
    logic [31:0] fifo_wr_word;
    logic [NUM_FIFOS-1:0] rd_clear;
    logic [NUM_FIFOS-1:0][1:0] fifo_prio;
    logic arb_valid;
    logic [FIFO_IDX_W-1:0] arb_index;

    assign dir_wr_word = merge_strb(dir_r, wdata_r, wstrb_r);
    assign fifo_wr_word = merge_strb({25'b0, fifo_ctl[wr_idx]}, wdata_r,
        wstrb_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_r <= DIR_RESET;
        end else if (wr_dir && cfg_mode) begin
            dir_r <= dir_wr_word;
        end
    end

    for (genvar n = 0; n < NUM_FIFOS; n++) begin : g_fifo
        can_fifo_ctl u_fifo (
            .aclk(aclk),
            .aresetn(aresetn),
            .cfg_mode(cfg_mode),
            .is_tx(dir_r[n]),
            .wr_en(wr_fifo && wr_idx == FIFO_IDX_W'(n)),
            .wr_val(fifo_ctl_t'(fifo_wr_word[6:0])),
            .rd_clear(rd_clear[n]),
            .evt(fifo_evt[n]),
            .ctl(fifo_ctl[n]),
            .abort_req(abort_request[n])
        );
        assign send_request[n] = fifo_ctl[n].send_req;
        assign fifo_prio[n] = fifo_ctl[n].prio;
    end

    // a fifo under abort is no longer offered to the bus
    can_tx_arbiter u_arb (
        .req(send_request & dir_r & ~abort_request),
        .prio(fifo_prio),
        .valid(arb_valid),
        .index(arb_index)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_grant_valid <= 1'b0;
            tx_grant_index <= '0;
        end else begin
            tx_grant_valid <= arb_valid;
            tx_grant_index <= arb_index;
        end
    end

    // ==========================================
    // axi read channel
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [31:0] rd_val;
    logic rd_ok;

    wire rd_take = s_axi_arvalid & ~rvalid_r;
    wire rd_fifo_hit = (s_axi_araddr[11:7] == FIFO_BASE[11:7])
        & (s_axi_araddr[1:0] == 2'b00);
    wire [FIFO_IDX_W-1:0] rd_idx = s_axi_araddr[6:2];

    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0000_0000;
        rd_clear = '0;
        if (s_axi_araddr == OFF_MODULE_CONTROL) begin
            rd_val = ctl_word;
        end else if (s_axi_araddr == OFF_INT_FLAGS) begin
            rd_val = int_word;
        end else if (s_axi_araddr == OFF_TIMER) begin
            rd_val = {16'h0000, timer_r};
        end else if (s_axi_araddr == OFF_DIRECTION) begin
            rd_val = dir_r;
        end else if (rd_fifo_hit) begin
            rd_val = {25'b0, fifo_ctl[rd_idx]};
            rd_clear[rd_idx] = rd_take;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign module_enable = enable_r;
    assign current_operating_mode = cur_mode_r;
    assign fifo_direction_select = dir_r;
    assign free_running_timer = timer_r;

    // ==========================================
    // checks
    a_wake_flag_set: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wake_evt |=> flags_r[BIT_WAKE])
        else $error("wake flag not set");
    a_bus_error_set: assert property (@(posedge aclk)
        disable iff (!aresetn)
        bus_err_evt |=> flags_r[BIT_BUS_ERR])
        else $error("bus error flag not set");
    a_sys_error_set: assert property (@(posedge aclk)
        disable iff (!aresetn)
        sys_err_evt |=> flags_r[BIT_SYS_ERR])
        else $error("system error flag not set");
    a_rx_overflow_set: assert property (@(posedge aclk)
        disable iff (!aresetn)
        rx_ovf_evt |=> flags_r[BIT_RX_OVF])
        else $error("receive overflow flag not set");
    a_mode_change_set: assert property (@(posedge aclk)
        disable iff (!aresetn)
        mode_step |=> cur_mode_r == $past(req_mode_r) && flags_r[BIT_MODE])
        else $error("mode change not flagged");
    a_timer_wrap_set: assert property (@(posedge aclk)
        disable iff (!aresetn)
        enable_r && timer_r == TIMER_MAX
        |=> timer_r == '0 && flags_r[BIT_TIMER])
        else $error("timer wrap not flagged");
    a_rx_buffer_live: assert property (@(posedge aclk)
        disable iff (!aresetn)
        rd_take && s_axi_araddr == OFF_INT_FLAGS
        |=> s_axi_rdata[BIT_RX_BUF] == $past(rx_buf_pending))
        else $error("receive buffer flag does not follow pending");
    a_tx_buffer_live: assert property (@(posedge aclk)
        disable iff (!aresetn)
        rd_take && s_axi_araddr == OFF_INT_FLAGS
        |=> s_axi_rdata[BIT_TX_BUF] == $past(tx_buf_pending))
        else $error("transmit buffer flag does not follow pending");
    a_sys_error_keep: assert property (@(posedge aclk)
        disable iff (!aresetn)
        flags_r[BIT_SYS_ERR] && !en_rise |=> flags_r[BIT_SYS_ERR])
        else $error("system error flag cleared without off-on");
    a_grant_follows: assert property (@(posedge aclk)
        disable iff (!aresetn)
        arb_valid |=> tx_grant_valid && tx_grant_index == $past(arb_index))
        else $error("grant does not follow arbitration");

endmodule

// *** can_engine_model.sv ***
// partner model: protocol engine answering grants and aborts
`timescale 1ns/10ps
module can_engine_model
    import can_irq_pkg::*;
(
    input wire logic aclk,
    input wire logic go,
    input wire logic [NUM_FIFOS-1:0] abort_request,
    input wire logic tx_grant_valid,
    input wire logic [FIFO_IDX_W-1:0] tx_grant_index,
    input wire fifo_evt_t inj,
    input wire logic [FIFO_IDX_W-1:0] inj_idx,
    output fifo_evt_t [NUM_FIFOS-1:0] fifo_evt
);
    // ==========================================
    // one pulse per go, so no stray event between frames
    always_ff @(posedge aclk) begin
        fifo_evt <= '0;
        for (int i = 0; i < NUM_FIFOS; i++) begin
            if (go && abort_request[i]) begin
                fifo_evt[i].aborted <= 1'b1;
            end
        end
        if (go && tx_grant_valid) begin
            fifo_evt[tx_grant_index].done <= 1'b1;
        end
        if (inj != '0) begin
            fifo_evt[inj_idx] <= inj;
        end
    end
endmodule

// *** can_irq_and_tx_fifo_control_tb_top.sv ***
// testbench for the can interrupt and fifo control block
`timescale 1ns/10ps
module can_irq_and_tx_fifo_control_tb_top
    import can_irq_pkg::*;
;
    logic aclk = 0, aresetn = 0, go = 0, h, v;
    logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_bready = 1, s_axi_rready = 1;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic wake_evt = 0, bus_err_evt = 0, sys_err_evt = 0, rx_ovf_evt = 0;
    logic rx_buf_pending = 0, tx_buf_pending = 0;
    fifo_evt_t [NUM_FIFOS-1:0] fifo_evt;
    fifo_evt_t inj = '0;
    logic module_enable, tx_grant_valid;
    op_mode_t current_operating_mode;
    logic [NUM_FIFOS-1:0] fifo_direction_select, send_request, abort_request;
    logic [TIMER_W-1:0] free_running_timer;
    logic [FIFO_IDX_W-1:0] tx_grant_index, inj_idx = 0;
    int n_fail = 0, compares = 0, seed = 32'h71b4_12e4, p0, p1, n;
    always #2.5 aclk = ~aclk;
    can_irq_and_tx_fifo_control dut (.*);
    can_engine_model eng (.aclk(aclk), .go(go), .abort_request(abort_request),
        .tx_grant_valid(tx_grant_valid), .tx_grant_index(tx_grant_index),
        .inj(inj), .inj_idx(inj_idx), .fifo_evt(fifo_evt));
    // ==========================================
    // bus and compare tasks
    task automatic conclude;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] x);
        logic aw, w;
        s_axi_awaddr <= a;
        s_axi_wdata <= x;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        for (n = 0; n < 40; n++) begin
            #1;
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            v = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
            if (v) break;
        end
        if (n == 40) begin n_fail++; conclude(); end
    endtask
    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        for (n = 0; n < 40; n++) begin
            #1;
            h = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (h) s_axi_arvalid <= 0;
            if (v) break;
        end
        if (n == 40) begin n_fail++; conclude(); end
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        ck(d, e);
    endtask
    // engine pulse: inject an event, or let the model answer
    task automatic ev(input logic [5:0] e, input logic [4:0] i, input logic g);
        inj <= e;
        inj_idx <= i;
        go <= g;
        @(posedge aclk);
        inj <= '0;
        go <= 0;
        repeat (2) @(posedge aclk);
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        ck(current_operating_mode, 4);
        wr(12'h00C, 7);
        ck(r, 0);
        ck(fifo_direction_select, 7);
        for (int k = 0; k < 4; k++) begin
            p0 = $random(seed) & 3;
            p1 = $random(seed) & 3;
            wr(12'h100, 8 | p0);
            wr(12'h104, 8 | p1);
            repeat (2) @(posedge aclk);
            ck(tx_grant_valid, 1);
            ck(tx_grant_index, p1 > p0);
            ev(0, 0, 1);
            ck(send_request[1:0], (p1 > p0) ? 1 : 2);
            ev(0, 0, 1);
            ck(send_request[1:0], 0);
        end
        wr(12'h100, 8);
        wr(12'h100, 0);
        ck({abort_request[0], send_request[0]}, 3);
        ev(0, 0, 1);
        rc(12'h100, 32'h0000_0040);
        ev(6'b001100, 0, 0);
        rc(12'h100, 32'h0000_0070);
        rc(12'h100, 32'h0000_0040);
        ev(6'b000001, 0, 0);
        rc(12'h100, 0);
        wr(12'h114, 8);
        rc(12'h114, 0);
        wr(12'h108, 4);
        ev(6'b000010, 2, 0);
        ev(6'b000010, 1, 0);
        ck(send_request[2:1], 2);
        ev(6'b000001, 2, 0);
        {wake_evt, bus_err_evt, sys_err_evt, rx_ovf_evt} <= 4'hf;
        {rx_buf_pending, tx_buf_pending} <= 2'h3;
        @(posedge aclk);
        {wake_evt, bus_err_evt, sys_err_evt, rx_ovf_evt} <= 4'h0;
        rc(12'h004, 32'h0000_7803);
        {rx_buf_pending, tx_buf_pending} <= 2'h0;
        wr(12'h004, 32'h0000_7fff);
        rc(12'h004, 32'h0000_1000);
        // turning the module on from off clears the system error flag
        wr(12'h000, 32'h0000_8000);
        @(posedge aclk);
        ck(current_operating_mode, 0);
        ck(module_enable, 1);
        rc(12'h004, 32'h0000_0008);
        p0 = free_running_timer;
        @(posedge aclk);
        ck(free_running_timer, (p0 + 1) & 16'hffff);
        wr(12'h104, 3);
        rc(12'h104, p1);
        wr(12'h00C, 0);
        ck(fifo_direction_select, 7);
        sys_err_evt <= 1;
        @(posedge aclk);
        sys_err_evt <= 0;
        wr(12'h004, 32'h0000_1008);
        rc(12'h004, 32'h0000_1000);
        wr(12'h000, 0);
        rc(12'h004, 32'h0000_1000);
        wr(12'h000, 32'h0000_8000);
        rc(12'h004, 32'h0000_0000);
        // one full timer period while enabled must wrap once
        repeat (65536) @(posedge aclk);
        rc(12'h004, 32'h0000_0004);
        wr(12'h010, 0);
        ck(r, 2);
        rd(12'h010);
        ck(r, 2);
        ck(d, 0);
        conclude();
    end
endmodule
